// *** core/bat_entry_table.sv ***
// storage of the block translation table entries
`timescale 1ns/1ns
module bat_entry_table #(
  parameter int NUM_ENTRIES = 6
) (
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  input  wire logic               clkEn,
  input  wire logic               wrEn,
  input  wire logic [2:0]         wrIdx,
  input  wire bat_pkg::entry_type wrData,
  input  wire logic [2:0]         rdIdx,
  output bat_pkg::entry_type      rdData,
  bat_lookup_if.table_side        lookup
);
  typedef struct packed {
    bat_pkg::entry_type [NUM_ENTRIES-1:0] ent;
  } state_type;
  state_type st;
  state_type next_st;

  // write the indexed entry
  always_comb begin
    next_st = st;
    if (wrEn && (32'(wrIdx) < NUM_ENTRIES)) begin
      next_st.ent[wrIdx] = wrData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  // read ports, unimplemented indices read as zero
  always_comb begin
    rdData = '0;
    lookup.entry = '0;
    if (32'(rdIdx) < NUM_ENTRIES) begin
      rdData = st.ent[rdIdx];
    end
    if (32'(lookup.sel) < NUM_ENTRIES) begin
      lookup.entry = st.ent[lookup.sel];
    end
  end
endmodule : bat_entry_table

// *** core/bat_lookup_if.sv ***
// lookup request and result between translator and table
`timescale 1ns/1ns
interface bat_lookup_if;
  logic [2:0]          sel;
  bat_pkg::entry_type  entry;
  modport requester (output sel, input entry);
  modport table_side (input sel, output entry);
endinterface : bat_lookup_if

// *** core/bat_pkg.sv ***
// constants and types for the block address translator
package bat_pkg;
  localparam int PAGE_SHIFT    = 12;
  localparam int MAX_ENTRIES   = 6;
  localparam int IDX_W         = 3;
  // register byte offsets
  localparam logic [7:0] OFF_INDEX   = 8'h00;
  localparam logic [7:0] OFF_HIGH    = 8'h04;
  localparam logic [7:0] OFF_LOW0    = 8'h08;
  localparam logic [7:0] OFF_CMD     = 8'h0C;
  localparam logic [7:0] OFF_CONFIG  = 8'h10;
  localparam logic [7:0] OFF_STATUS  = 8'h14;
  localparam logic [7:0] OFF_MASK    = 8'h18;
  localparam logic [7:0] OFF_FAULTVA = 8'h1C;
  // entry low0 field positions
  localparam int LOW_V_BIT   = 1;
  localparam int LOW_D_BIT   = 2;
  localparam int LOW_C_LSB   = 3;
  localparam int LOW_PFN_LSB = 6;
  // second config register size field position
  localparam int CFG_SIZE_LSB = 25;
  // command codes
  localparam logic [1:0] CMD_WRITE_IDX = 2'h0;
  localparam logic [1:0] CMD_READ      = 2'h1;
  localparam logic [1:0] CMD_PROBE     = 2'h2;
  localparam logic [1:0] CMD_RANDOM    = 2'h3;
  // status bits
  localparam int ST_INV_I  = 0;
  localparam int ST_INV_D  = 1;
  localparam int ST_MOD    = 2;
  localparam int ST_RSVD   = 3;
  localparam int ST_W      = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  typedef struct packed {
    logic [19:0] boundsPage;
    logic [19:0] baseFrame;
    logic [2:0]  coherence;
    logic        dirty;
    logic        valid;
  } entry_type;
endpackage : bat_pkg

// *** core/bat_region_select.sv ***
// picks the entry number from reference type and region
`timescale 1ns/1ns
module bat_region_select #(
  parameter int NUM_ENTRIES = 6
) (
  input  wire logic        isData,
  input  wire logic [31:0] va,
  bat_lookup_if.requester  lookup
);
  logic upper;
  logic top;
  assign upper = va[31:29] == 3'h6;
  assign top   = va[31:29] == 3'h7;

  // region select
  always_comb begin
    lookup.sel = {2'h0, isData};
    if (upper || top) begin
      if (NUM_ENTRIES >= 6 && top) begin
        lookup.sel = 3'(4 + int'(isData));
      end else begin
        lookup.sel = 3'(2 + int'(isData));
      end
    end
  end
endmodule : bat_region_select

// *** core/block_address_translator.sv ***
// block address translator with AHB-Lite register access
//
// The implementer's own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ns
module block_address_translator #(
  parameter int NUM_ENTRIES = 6
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        clkEn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic [1:0]       hresp,
  // translation request
  input  wire logic        reqValid,
  input  wire logic        reqData,
  input  wire logic        reqStore,
  input  wire logic [31:0] reqVa,
  output logic             rspValid,
  output logic [31:0]      rspPa,
  output logic             rspAccess,
  output logic             rspInvalid,
  output logic             rspModified,
  output logic             rspData,
  // instruction decode hook
  input  wire logic        probeInstr,
  input  wire logic        randomWriteInstr,
  output logic             reservedInstr,
  output logic             irq
);
  typedef struct packed {
    logic                  dPend;
    logic                  dWrite;
    logic [7:0]            dAddr;
    logic [31:0]           rdata;
    logic [2:0]            index;
    logic [19:0]           highPage;
    logic [31:0]           low0;
    logic [bat_pkg::ST_W-1:0] status;
    logic [bat_pkg::ST_W-1:0] mask;
    logic [31:0]           faultVa;
    logic                  rspValid;
    logic [31:0]           rspPa;
    logic                  rspAccess;
    logic                  rspInvalid;
    logic                  rspModified;
    logic                  rspData;
    logic                  rsvd;
    logic                  irq;
  } state_type;

  state_type st;
  state_type next_st;

  bat_lookup_if       lk ();
  logic               tblWr;
  bat_pkg::entry_type tblWrData;
  bat_pkg::entry_type tblRdData;
  bat_pkg::entry_type sel;
  logic [31:0]        bounds;
  logic               outOfRange;
  logic               badValid;
  logic               badDirty;
  logic [31:0]        paCalc;
  logic               cmdHit;
  logic [1:0]         cmdCode;
  logic [bat_pkg::ST_W-1:0] events;

  bat_region_select #(
    .NUM_ENTRIES (NUM_ENTRIES)
  ) u_sel (
    .isData (reqData),
    .va     (reqVa),
    .lookup (lk)
  );

  bat_entry_table #(
    .NUM_ENTRIES (NUM_ENTRIES)
  ) u_tbl (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clkEn    (clkEn),
    .wrEn     (tblWr),
    .wrIdx    (st.index),
    .wrData   (tblWrData),
    .rdIdx    (st.index),
    .rdData   (tblRdData),
    .lookup   (lk)
  );

  // translation checks on the selected entry
  assign sel        = lk.entry;
  assign bounds     = {sel.boundsPage, 12'hFFF};
  assign outOfRange = reqVa > bounds;
  assign badValid   = outOfRange || !sel.valid;
  assign badDirty   = reqStore && !sel.dirty;
  assign paCalc     = reqVa + {sel.baseFrame, 12'h000};

  // indexed write pulls from entry high and entry low0
  assign tblWrData.boundsPage = st.highPage;
  assign tblWrData.baseFrame  = st.low0[bat_pkg::LOW_PFN_LSB +: 20];
  assign tblWrData.coherence  = st.low0[bat_pkg::LOW_C_LSB +: 3];
  assign tblWrData.dirty      = st.low0[bat_pkg::LOW_D_BIT];
  assign tblWrData.valid      = st.low0[bat_pkg::LOW_V_BIT];

  assign cmdHit  = st.dPend && st.dWrite && st.dAddr == bat_pkg::OFF_CMD;
  assign cmdCode = hwdata[1:0];
  assign tblWr   = cmdHit && cmdCode == bat_pkg::CMD_WRITE_IDX;

  // events captured into status
  always_comb begin
    events = '0;
    if (reqValid) begin
      events[bat_pkg::ST_INV_I] = badValid && !reqData;
      events[bat_pkg::ST_INV_D] = badValid && reqData;
      events[bat_pkg::ST_MOD]   = !badValid && badDirty;
    end
    events[bat_pkg::ST_RSVD] = probeInstr || randomWriteInstr ||
      (cmdHit && (cmdCode == bat_pkg::CMD_PROBE ||
                  cmdCode == bat_pkg::CMD_RANDOM));
  end

  // next state: bus, registers, translation response
  always_comb begin
    next_st = st;
    // address phase capture
    next_st.dPend = hsel && hready && htrans[1];
    if (hsel && hready && htrans[1]) begin
      next_st.dWrite = hwrite;
      next_st.dAddr  = haddr[7:0];
    end
    // data phase write
    if (st.dPend && st.dWrite) begin
      unique case (st.dAddr)
        bat_pkg::OFF_INDEX: next_st.index = hwdata[2:0];
        bat_pkg::OFF_HIGH:  next_st.highPage = hwdata[31:12];
        bat_pkg::OFF_LOW0:  next_st.low0 = hwdata;
        bat_pkg::OFF_CMD: begin
          if (cmdCode == bat_pkg::CMD_READ) begin
            next_st.highPage = tblRdData.boundsPage;
            next_st.low0 = '0;
            next_st.low0[bat_pkg::LOW_PFN_LSB +: 20] = tblRdData.baseFrame;
            next_st.low0[bat_pkg::LOW_C_LSB +: 3] = tblRdData.coherence;
            next_st.low0[bat_pkg::LOW_D_BIT] = tblRdData.dirty;
            next_st.low0[bat_pkg::LOW_V_BIT] = tblRdData.valid;
          end
        end
        bat_pkg::OFF_STATUS:
          next_st.status = st.status & ~hwdata[bat_pkg::ST_W-1:0];
        bat_pkg::OFF_MASK: next_st.mask = hwdata[bat_pkg::ST_W-1:0];
        default: ;
      endcase
    end
    // set wins over clear
    next_st.status = next_st.status | events;
    // read data for next data phase, sees a write ending this cycle
    next_st.rdata = '0;
    if (hsel && hready && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        bat_pkg::OFF_INDEX:  next_st.rdata = {29'h0, next_st.index};
        bat_pkg::OFF_HIGH:   next_st.rdata = {next_st.highPage, 12'h000};
        bat_pkg::OFF_LOW0:   next_st.rdata = next_st.low0;
        bat_pkg::OFF_CONFIG: next_st.rdata =
          32'((NUM_ENTRIES - 1) << bat_pkg::CFG_SIZE_LSB);
        bat_pkg::OFF_STATUS: next_st.rdata = 32'(next_st.status);
        bat_pkg::OFF_MASK:   next_st.rdata = 32'(next_st.mask);
        bat_pkg::OFF_FAULTVA: next_st.rdata = st.faultVa;
        default: next_st.rdata = '0;
      endcase
    end
    // translation response, one cycle after the request
    next_st.rspValid    = reqValid;
    next_st.rspData     = reqData;
    next_st.rspInvalid  = reqValid && badValid;
    next_st.rspModified = reqValid && !badValid && badDirty;
    next_st.rspAccess   = reqValid && !badValid && !badDirty;
    next_st.rspPa = (reqValid && !badValid && !badDirty) ? paCalc : '0;
    if (reqValid && (badValid || badDirty)) begin
      next_st.faultVa = reqVa;
    end
    next_st.rsvd = events[bat_pkg::ST_RSVD];
    next_st.irq  = |(next_st.status & next_st.mask);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  // outputs straight from state, hreadyout and hresp tied constant
  assign hrdata        = st.rdata;
  assign hreadyout     = 1'b1;
  assign hresp         = bat_pkg::RESP_OKAY;
  assign rspValid      = st.rspValid;
  assign rspPa         = st.rspPa;
  assign rspAccess     = st.rspAccess;
  assign rspInvalid    = st.rspInvalid;
  assign rspModified   = st.rspModified;
  assign rspData       = st.rspData;
  assign reservedInstr = st.rsvd;
  assign irq           = st.irq;
endmodule : block_address_translator

// *** dv/bat_checker_asserts.sv ***
// port assertions for the translator
`timescale 1ns/1ns
module bat_checker #(
  parameter int NUM_ENTRIES = 6
) (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        clkEn,
  input wire logic        reqValid,
  input wire logic        reqData,
  input wire logic        reqStore,
  input wire logic [31:0] reqVa,
  input wire logic        rspValid,
  input wire logic [31:0] rspPa,
  input wire logic        rspAccess,
  input wire logic        rspInvalid,
  input wire logic        rspModified,
  input wire logic        rspData,
  input wire logic        probeInstr,
  input wire logic        randomWriteInstr,
  input wire logic        reservedInstr
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // answer timing and outcome of a lookup, and the reserved instruction fault
  rsp_after_req_a: assert property (
    reqValid && clkEn |=> rspValid) else $error("no answer");
  rsp_needs_req_a: assert property (
    rspValid |-> $past(reqValid)) else $error("stray answer");
  one_outcome_a: assert property (
    $onehot({rspAccess, rspInvalid, rspModified}) == rspValid)
    else $error("outcome count");
  fault_no_pa_a: assert property (
    rspInvalid || rspModified |-> rspPa == 32'h0) else $error("fault pa");
  type_echo_a: assert property (
    rspValid |-> rspData == $past(reqData)) else $error("type echo");
  mod_on_store_a: assert property (
    rspModified |-> $past(reqStore)) else $error("modified on load");
  page_offset_a: assert property (
    rspAccess |-> ((rspPa ^ $past(reqVa)) & 32'hFFF) == 32'h0)
    else $error("page offset");
  reserved_fault_a: assert property (
    (probeInstr || randomWriteInstr) && clkEn |=> reservedInstr)
    else $error("no reserved");
  // main scenarios
  cover property (rspAccess);
  cover property (rspModified);
  cover property (reservedInstr);
endmodule : bat_checker

bind block_address_translator bat_checker #(.NUM_ENTRIES(NUM_ENTRIES)) u_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn),
  .reqValid(reqValid), .reqData(reqData), .reqStore(reqStore),
  .reqVa(reqVa), .rspValid(rspValid), .rspPa(rspPa),
  .rspAccess(rspAccess), .rspInvalid(rspInvalid),
  .rspModified(rspModified), .rspData(rspData),
  .probeInstr(probeInstr), .randomWriteInstr(randomWriteInstr),
  .reservedInstr(reservedInstr));

// *** dv/block_address_translator_test.sv ***
// self-checking bench for the translator
`timescale 1ns/1ns
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin fails++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module block_address_translator_test;
  localparam int N = 6;
  logic        core_clk = 1'b0, sys_rst = 1'b1, hwrite = 1'b0;
  logic        probeInstr = 1'b0, randomWriteInstr = 1'b0, y;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, x;
  wire logic        hready, reqValid, reqData, reqStore, rspValid;
  wire logic        rspAccess, rspInvalid, rspModified, rspData, irq;
  wire logic        reservedInstr;
  wire logic [31:0] hrdata, reqVa, rspPa;
  wire logic [1:0]  hresp;
  int          totalChecks = 0, fails = 0;
  // design under test and processor model
  block_address_translator #(.NUM_ENTRIES(N)) u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(1'b1), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hresp(hresp),
    .hreadyout(hready), .reqValid(reqValid), .reqData(reqData),
    .reqStore(reqStore), .reqVa(reqVa), .rspValid(rspValid),
    .rspPa(rspPa), .rspAccess(rspAccess), .rspInvalid(rspInvalid),
    .rspModified(rspModified), .rspData(rspData), .irq(irq),
    .probeInstr(probeInstr), .randomWriteInstr(randomWriteInstr),
    .reservedInstr(reservedInstr));
  core_model cpu (.core_clk(core_clk), .reqValid(reqValid),
    .reqData(reqData), .reqStore(reqStore), .reqVa(reqVa));
  // 25 MHz clock
  always #20 core_clk = ~core_clk;
  // single word transfer, read data left in x
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    x = hrdata;
  endtask : bus
  task automatic rdc(logic [7:0] a, logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(x, e)
    `CHK(hresp, bat_pkg::RESP_OKAY)
  endtask : rdc
  task automatic prog(logic [2:0] i, logic [31:0] hi, lo);
    bus(1'b1, bat_pkg::OFF_INDEX, 32'(i));
    bus(1'b1, bat_pkg::OFF_HIGH, hi);
    bus(1'b1, bat_pkg::OFF_LOW0, lo);
    bus(1'b1, bat_pkg::OFF_CMD, 32'(bat_pkg::CMD_WRITE_IDX));
  endtask : prog
  // one lookup, outcome as {access, invalid, modified}
  task automatic xl(logic d, s, logic [31:0] va, pa, logic [2:0] r);
    cpu.issue(d, s, va);
    #1;
    `CHK({rspValid,rspAccess,rspInvalid,rspModified,rspData}, {1'b1,r,d})
    `CHK(rspPa, pa)
    @(posedge core_clk);
  endtask : xl
  // size field, unmapped place, entry write and read back
  task automatic t_regs;
    rdc(bat_pkg::OFF_CONFIG, 32'(N - 1) << bat_pkg::CFG_SIZE_LSB);
    rdc(8'h20, 32'h0);
    prog(3'h1, 32'h10000, 32'h401A);
    prog(3'h0, 32'h0, 32'h8006);
    bus(1'b1, bat_pkg::OFF_INDEX, 32'h1);
    rdc(bat_pkg::OFF_INDEX, 32'h1);
    bus(1'b1, bat_pkg::OFF_CMD, 32'(bat_pkg::CMD_READ));
    rdc(bat_pkg::OFF_HIGH, 32'h10000);
    rdc(bat_pkg::OFF_LOW0, 32'h401A);
    $display("regs done");
  endtask : t_regs
  // bounds edges, dirty, regions and a cleared valid bit
  task automatic t_xlate;
    xl(1'b1, 1'b0, 32'h10FFF, 32'h110FFF, 3'b100);
    xl(1'b1, 1'b0, 32'h11000, 32'h0, 3'b010);
    xl(1'b1, 1'b1, 32'h100, 32'h0, 3'b001);
    xl(1'b0, 1'b0, 32'hFFF, 32'h200FFF, 3'b100);
    xl(1'b0, 1'b0, 32'h1000, 32'h0, 3'b010);
    prog(3'h5, 32'hFFFFF000, 32'h6);
    xl(1'b1, 1'b1, 32'hE0001234, 32'hE0001234, 3'b100);
    xl(1'b1, 1'b0, 32'hC0000000, 32'h0, 3'b010);
    xl(1'b0, 1'b0, 32'hE0000000, 32'h0, 3'b010);
    rdc(bat_pkg::OFF_FAULTVA, 32'hE0000000);
    prog(3'h1, 32'hFFFFF000, 32'h4004);
    xl(1'b1, 1'b0, 32'h0, 32'h0, 3'b010);
    $display("xlate done");
  endtask : t_xlate
  // event status, mask, clear, reserved instruction fault
  task automatic t_irq;
    bus(1'b1, bat_pkg::OFF_MASK, 32'h0);
    rdc(bat_pkg::OFF_STATUS, 32'h7);
    y = irq;
    bus(1'b1, bat_pkg::OFF_MASK, 32'hF);
    rdc(bat_pkg::OFF_MASK, 32'hF);
    rdc(bat_pkg::OFF_STATUS, 32'h7);
    `CHK(y ^ irq, 1'b1)
    bus(1'b1, bat_pkg::OFF_STATUS, 32'h7);
    rdc(bat_pkg::OFF_STATUS, 32'h0);
    `CHK(irq, 1'b0)
    probeInstr <= 1'b1;
    @(posedge core_clk);
    probeInstr <= 1'b0;
    randomWriteInstr <= 1'b1;
    #1 `CHK(reservedInstr, 1'b1)
    @(posedge core_clk);
    randomWriteInstr <= 1'b0;
    #1 `CHK(reservedInstr, 1'b1)
    @(posedge core_clk);
    #1 `CHK(reservedInstr, 1'b0)
    @(posedge core_clk);
    bus(1'b1, bat_pkg::OFF_STATUS, 32'hF);
    rdc(bat_pkg::OFF_STATUS, 32'h0);
    bus(1'b1, bat_pkg::OFF_CMD, 32'(bat_pkg::CMD_PROBE));
    rdc(bat_pkg::OFF_STATUS, 32'h8);
    bus(1'b1, bat_pkg::OFF_STATUS, 32'h8);
    bus(1'b1, bat_pkg::OFF_CMD, 32'(bat_pkg::CMD_RANDOM));
    rdc(bat_pkg::OFF_STATUS, 32'h8);
    $display("irq done");
  endtask : t_irq
  task automatic print_verdict;
    $display("checks %0d fails %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  // reset, then the scenarios
  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_xlate();
    t_irq();
    print_verdict();
  end
  // watchdog
  initial begin
    #100000;
    fails++;
    print_verdict();
  end
endmodule : block_address_translator_test

// *** dv/core_model.sv ***
// processor side model issuing lookups
`timescale 1ns/1ns
module core_model (
  input  wire logic   core_clk,
  output logic        reqValid = 1'b0,
  output logic        reqData = 1'b0,
  output logic        reqStore = 1'b0,
  output logic [31:0] reqVa = 32'h0
);
  // one request; address scrambled once taken
  task automatic issue(logic d, s, logic [31:0] va);
    reqValid <= 1'b1;
    reqData <= d;
    reqStore <= s;
    reqVa <= va;
    @(posedge core_clk);
    reqValid <= 1'b0;
    reqVa <= ~va;
  endtask : issue
endmodule : core_model
